// *** src/trace_bkpt_regs.svh ***
/*
  Constants of the trace and breakpoint fault unit: register placement,
  field positions, reset values and encodings.
  Assumes inclusion by bare name.
*/
// What this block does
// - Breakpoint word: address high, mode low
// - Trace flag clear or mode 00: no action
// - Read via sysctl only; write sysctl/word store
// - Group, fault call, mark, fmark raise trace
// - Instruction or data breakpoint match raises trace
// - Prereturn alone; others may share record
// - Others first, prereturn after handler returns
// - Trace handler entry clears trace flag
// - Supervisor fault calls load flag from table bit
// - Interrupt saves controls, clears flag; return restores
// - Calls traced with flag after call
// - Explicit call traced before callee runs
// - Local, extended, supervisor calls: keep, type 000
// - User system call: cached bit, type 01a
// - Implicit call traced before handler runs
// - Local fault calls keep flag, type 001
// - Parallel and trace handlers: 001, flag 0
// - Interrupt call: 111, flag 0, untraced
// - Traced fault call leaves fault IP undefined
// - Data match: access type and any byte
`ifndef TRACE_BKPT_REGS_SVH
`define TRACE_BKPT_REGS_SVH

// Memory-mapped placement of the instruction breakpoint words
`define IBP_BASE_ADDR 32'hff00_8400
`define IBP_STRIDE 32'h0000_0004
`define IBP_RESET 32'h0000_0000
`define IBP_ADDR_MSB 31
`define IBP_ADDR_LSB 2
`define IBP_MODE_HIGH 1
`define IBP_MODE_LOW 0
`define IBP_MODE_OFF 2'h0
`define IBP_MODE_TRACE 2'h3
`define WORD_STROBE 4'hf

// Data breakpoint access modes
`define DAB_MODE_WRITE 2'h0
`define DAB_MODE_READ 2'h2

// Return type field codes
`define RET_LOCAL 3'h0
`define RET_FAULT 3'h1
`define RET_SYS_HIGH 2'h1
`define RET_INTR 3'h7

// Trace record event bits
`define TREC_W 8
`define TREC_GROUP 0
`define TREC_CALL 1
`define TREC_MARK 2
`define TREC_FMARK 3
`define TREC_IBP 4
`define TREC_DAB 5
`define TREC_SUPER 6
`define TREC_PRERET 7

`endif

// *** src/trace_bkpt_pkg.sv ***
/*
  Types shared by the trace and breakpoint fault unit.
  Assumes nothing of its surroundings.
*/
package trace_bkpt_pkg;
  typedef enum logic [2:0] {
    CALL_LOCAL = 3'h0,
    CALL_SYS = 3'h1,
    FLT_LOCAL = 3'h2,
    FLT_SYSLOCAL = 3'h3,
    FLT_SUPER = 3'h4,
    FLT_TRACE = 3'h5,
    FLT_PAROVR = 3'h6,
    CALL_INTR = 3'h7
  } call_kind_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_DEFER = 2'b10
  } report_state_type;
endpackage : trace_bkpt_pkg

// *** src/bkpt_match_if.sv ***
/*
  Carrier between the fault unit and its breakpoint matcher.
  Assumes combinational drive within one clock.
*/
`timescale 1ns/10ps
interface bkpt_match_if #(
  parameter int NUM_IBP = 2,
  parameter int NUM_DAB = 2
);
  logic [NUM_IBP-1:0][31:0] ibpWords;
  logic traceOn;
  logic ipValid;
  logic [31:0] ip;
  logic accValid;
  logic accWrite;
  logic [31:0] accAddr;
  logic [2:0] accSizeLog;
  logic [NUM_DAB-1:0][31:0] dabAddr;
  logic [NUM_DAB-1:0] dabEn;
  logic [NUM_DAB-1:0][1:0] dabMode;
  logic ibpHit;
  logic dabHit;

  modport matcher (
    input ibpWords, traceOn, ipValid, ip, accValid, accWrite, accAddr, accSizeLog,
    input dabAddr, dabEn, dabMode,
    output ibpHit, dabHit
  );
  modport core (
    output ibpWords, traceOn, ipValid, ip, accValid, accWrite, accAddr, accSizeLog,
    output dabAddr, dabEn, dabMode,
    input ibpHit, dabHit
  );
endinterface : bkpt_match_if

// *** src/bkpt_matcher.sv ***
/*
  Address comparators for instruction and data breakpoints.
  Assumes the carrier's trace flag is the one in force.
*/
`timescale 1ns/10ps
`include "trace_bkpt_regs.svh"
module bkpt_matcher #(
  parameter int NUM_IBP = 2,
  parameter int NUM_DAB = 2
) (
  input wire logic sys_clk,
  input wire logic rstSync_n,
  bkpt_match_if.matcher mi
);
  function automatic logic ibpHitOne(input logic [31:0] word, input logic [31:0] ip);
    ibpHitOne = (word[`IBP_MODE_HIGH:`IBP_MODE_LOW] == `IBP_MODE_TRACE) &&
      (word[`IBP_ADDR_MSB:`IBP_ADDR_LSB] == ip[`IBP_ADDR_MSB:`IBP_ADDR_LSB]);
  endfunction : ibpHitOne

  // Reserved modes 01 and 10 act as off
  always_comb begin
    mi.ibpHit = 1'b0;
    for (int i = 0; i < NUM_IBP; i++) begin
      if (mi.traceOn && mi.ipValid && ibpHitOne(mi.ibpWords[i], mi.ip)) begin
        mi.ibpHit = 1'b1;
      end
    end
  end

  logic [32:0] accEnd;
  logic typeOk;
  always_comb begin
    mi.dabHit = 1'b0;
    accEnd = {1'b0, mi.accAddr} + (33'h1 << mi.accSizeLog);
    for (int i = 0; i < NUM_DAB; i++) begin
      typeOk = (mi.dabMode[i] == `DAB_MODE_WRITE) ? mi.accWrite :
        (mi.dabMode[i] == `DAB_MODE_READ) ? !mi.accWrite : 1'b1;
      // Any referenced byte counts, aligned or not
      if (mi.traceOn && mi.accValid && mi.dabEn[i] && typeOk &&
          mi.dabAddr[i] >= mi.accAddr && {1'b0, mi.dabAddr[i]} < accEnd) begin
        mi.dabHit = 1'b1;
      end
    end
  end

  a_ibp_mode_off: assert property (@(posedge sys_clk) disable iff (!rstSync_n)
    (mi.ibpWords[0][1:0] == `IBP_MODE_OFF) &&
    (mi.ibpWords[NUM_IBP-1][1:0] == `IBP_MODE_OFF) |-> !mi.ibpHit)
    else $error("disabled breakpoint matched");
  a_dab_byte_hit: assert property (@(posedge sys_clk) disable iff (!rstSync_n)
    mi.traceOn && mi.accValid && mi.dabEn[0] && !mi.accWrite &&
    (mi.dabMode[0] == `DAB_MODE_READ) &&
    (mi.dabAddr[0] == mi.accAddr) |-> mi.dabHit)
    else $error("data breakpoint missed first byte");
endmodule : bkpt_matcher

// *** src/trace_breakpoint_fault_unit.sv ***
/*
  Trace event and breakpoint logic: breakpoint words, trace flag upkeep
  on calls, returns and interrupts, and trace fault reporting.
  Assumes one-cycle strobes and a FLT_TRACE call after each report.
*/
`timescale 1ns/10ps
`include "trace_bkpt_regs.svh"
module trace_breakpoint_fault_unit #(
  parameter int NUM_IBP = 2,
  parameter int NUM_DAB = 2,
  parameter int IDX_W = 1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // System-control access to breakpoint words
  input wire logic sysctlValid,
  input wire logic sysctlWrite,
  input wire logic [IDX_W-1:0] sysctlIndex,
  input wire logic [31:0] sysctlWdata,
  output logic sysctlRvalid,
  output logic [31:0] sysctlRdata,
  // Memory-mapped store port
  input wire logic storeValid,
  input wire logic [31:0] storeAddr,
  input wire logic [3:0] storeByteEn,
  input wire logic [31:0] storeData,
  // Retired instruction and its trace events
  input wire logic retireValid,
  input wire logic [31:0] retireIp,
  input wire logic groupEvt,
  input wire logic supervisorEvt,
  input wire logic markEvt,
  input wire logic fmarkEvt,
  input wire logic prereturnEvt,
  input wire logic breakpointTraceMode,
  input wire logic callTraceMode,
  // Data accesses and data breakpoint setup
  input wire logic accValid,
  input wire logic accWrite,
  input wire logic [31:0] accAddr,
  input wire logic [2:0] accSizeLog,
  input wire logic [NUM_DAB-1:0][31:0] dabAddr,
  input wire logic [NUM_DAB-1:0] dabEn,
  input wire logic [NUM_DAB-1:0][1:0] dabMode,
  // Calls, returns and initialization
  input wire logic callValid,
  input wire trace_bkpt_pkg::call_kind_type callKind,
  input wire logic execSuper,
  input wire logic sptTraceBit,
  input wire logic initLoad,
  input wire logic initSspTraceBit,
  input wire logic retValid,
  input wire logic [2:0] retType,
  input wire logic retTraceRestore,
  input wire logic traceHandlerDone,
  // Trace state and fault requests
  output logic traceEnable,
  output logic [2:0] pfpReturnType,
  output logic intSavedTrace,
  output logic traceReq,
  output logic [`TREC_W-1:0] traceRecord,
  output logic faultIpDefined,
  output logic prereturnPending
);
  if (NUM_IBP < 1 || NUM_DAB < 1 || (1 << IDX_W) < NUM_IBP) begin : g_badParams
    $error("breakpoint counts or index width unusable");
  end

  logic rstMeta_q, rstSync_q;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSync_q <= rstMeta_q;
    end
  end

  // Breakpoint words
  logic [NUM_IBP-1:0][31:0] ibp_q;
  logic storeHit;
  logic [IDX_W-1:0] storeIdx;
  logic [31:0] storeOff;
  always_comb begin
    storeOff = storeAddr - `IBP_BASE_ADDR;
    storeIdx = storeOff[IDX_W+1:2];
    // Only aligned full-word stores in range write
    if (!storeValid) begin
      storeHit = 1'b0;
    end else if (storeByteEn != `WORD_STROBE) begin
      storeHit = 1'b0;
    end else if (storeAddr < `IBP_BASE_ADDR || storeOff[1:0] != 2'h0) begin
      storeHit = 1'b0;
    end else if (storeOff[31:2] >= 30'(NUM_IBP)) begin
      storeHit = 1'b0;
    end else begin
      storeHit = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      ibp_q <= '{default: `IBP_RESET};
    end else if (sysctlValid && sysctlWrite && int'(sysctlIndex) < NUM_IBP) begin
      ibp_q[sysctlIndex] <= sysctlWdata;
    end else if (storeHit) begin
      ibp_q[storeIdx] <= storeData;
    end
  end

  // Only the sysctl path reads these words back
  always_ff @(posedge sys_clk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      sysctlRvalid <= 1'b0;
      sysctlRdata <= 32'h0000_0000;
    end else begin
      sysctlRvalid <= sysctlValid && !sysctlWrite;
      sysctlRdata <= (sysctlValid && !sysctlWrite && int'(sysctlIndex) < NUM_IBP) ?
        ibp_q[sysctlIndex] : 32'h0000_0000;
    end
  end

  // Flag after this cycle's call or return
  logic sspTe_q;
  logic teNext;
  logic [2:0] rrrNext;
  logic callTraced;
  always_comb begin
    teNext = traceEnable;
    rrrNext = pfpReturnType;
    callTraced = 1'b0;
    if (retValid && execSuper && retType != `RET_LOCAL) begin
      teNext = retTraceRestore;
    end
    if (callValid) begin
      case (callKind)
        trace_bkpt_pkg::CALL_LOCAL: begin
          rrrNext = `RET_LOCAL;
          callTraced = 1'b1;
        end
        trace_bkpt_pkg::CALL_SYS: begin
          if (execSuper) begin
            rrrNext = `RET_LOCAL;
          end else begin
            rrrNext = {`RET_SYS_HIGH, traceEnable};
            teNext = sspTe_q;
          end
          callTraced = 1'b1;
        end
        trace_bkpt_pkg::FLT_LOCAL, trace_bkpt_pkg::FLT_SYSLOCAL: begin
          rrrNext = `RET_FAULT;
          callTraced = 1'b1;
        end
        trace_bkpt_pkg::FLT_SUPER: begin
          rrrNext = `RET_FAULT;
          teNext = sptTraceBit;
          callTraced = 1'b1;
        end
        trace_bkpt_pkg::FLT_TRACE, trace_bkpt_pkg::FLT_PAROVR: begin
          rrrNext = `RET_FAULT;
          teNext = 1'b0;
        end
        default: begin
          rrrNext = `RET_INTR;
          teNext = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      sspTe_q <= 1'b0;
    end else if (initLoad) begin
      sspTe_q <= initSspTraceBit;
    end
  end

  always_ff @(posedge sys_clk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      traceEnable <= 1'b0;
      pfpReturnType <= `RET_LOCAL;
      intSavedTrace <= 1'b0;
    end else begin
      traceEnable <= teNext;
      pfpReturnType <= rrrNext;
      if (callValid && callKind == trace_bkpt_pkg::CALL_INTR) begin
        intSavedTrace <= traceEnable;
      end
    end
  end

  // Breakpoint comparison
  bkpt_match_if #(.NUM_IBP(NUM_IBP), .NUM_DAB(NUM_DAB)) mi ();
  assign mi.ibpWords = ibp_q;
  assign mi.traceOn = teNext;
  assign mi.ipValid = retireValid;
  assign mi.ip = retireIp;
  assign mi.accValid = accValid;
  assign mi.accWrite = accWrite;
  assign mi.accAddr = accAddr;
  assign mi.accSizeLog = accSizeLog;
  assign mi.dabAddr = dabAddr;
  assign mi.dabEn = dabEn;
  assign mi.dabMode = dabMode;

  bkpt_matcher #(.NUM_IBP(NUM_IBP), .NUM_DAB(NUM_DAB)) matcher (
    .sys_clk(sys_clk),
    .rstSync_n(rstSync_q),
    .mi(mi)
  );

  // Events use the flag in force after the instruction
  logic [`TREC_W-1:0] evts;
  logic isFaultCall;
  always_comb begin
    evts = '0;
    isFaultCall = callValid && callKind != trace_bkpt_pkg::CALL_LOCAL &&
      callKind != trace_bkpt_pkg::CALL_SYS;
    if (teNext) begin
      evts[`TREC_GROUP] = retireValid && groupEvt;
      evts[`TREC_SUPER] = retireValid && supervisorEvt;
      evts[`TREC_MARK] = retireValid && markEvt && breakpointTraceMode;
      evts[`TREC_FMARK] = retireValid && fmarkEvt;
      evts[`TREC_PRERET] = retireValid && prereturnEvt;
      evts[`TREC_CALL] = callValid && callTraced && callTraceMode;
      evts[`TREC_IBP] = mi.ibpHit;
      evts[`TREC_DAB] = mi.dabHit;
    end
  end

  // Request lands one cycle after the call, before the callee runs
  trace_bkpt_pkg::report_state_type state_q;
  logic [`TREC_W-1:0] others;
  always_comb begin
    others = evts;
    others[`TREC_PRERET] = 1'b0;
  end

  always_ff @(posedge sys_clk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      state_q <= trace_bkpt_pkg::ST_IDLE;
      traceReq <= 1'b0;
      traceRecord <= '0;
      faultIpDefined <= 1'b1;
      prereturnPending <= 1'b0;
    end else begin
      traceReq <= 1'b0;
      faultIpDefined <= !(isFaultCall && evts[`TREC_CALL]);
      case (state_q)
        trace_bkpt_pkg::ST_IDLE: begin
          if (evts[`TREC_PRERET] && others != '0) begin
            traceReq <= 1'b1;
            traceRecord <= others;
            prereturnPending <= 1'b1;
            state_q <= trace_bkpt_pkg::ST_DEFER;
          end else if (evts != '0) begin
            traceReq <= 1'b1;
            traceRecord <= evts;
          end
        end
        trace_bkpt_pkg::ST_DEFER: begin
          if (traceHandlerDone) begin
            traceReq <= 1'b1;
            traceRecord <= `TREC_W'(1) << `TREC_PRERET;
            prereturnPending <= 1'b0;
            state_q <= trace_bkpt_pkg::ST_IDLE;
          end else if (others != '0) begin
            traceReq <= 1'b1;
            traceRecord <= others;
          end
        end
        default: begin
          state_q <= trace_bkpt_pkg::ST_IDLE;
        end
      endcase
    end
  end

  a_te_gates_trace: assert property (@(posedge sys_clk) disable iff (!rstSync_q)
    !teNext && state_q == trace_bkpt_pkg::ST_IDLE |=> !traceReq)
    else $error("trace raised with flag clear");
  a_ibp_hit_trace: assert property (@(posedge sys_clk) disable iff (!rstSync_q)
    teNext && retireValid && ibp_q[0][1:0] == `IBP_MODE_TRACE &&
    ibp_q[0][31:2] == retireIp[31:2] && state_q == trace_bkpt_pkg::ST_IDLE
    |=> traceReq && traceRecord[`TREC_IBP])
    else $error("breakpoint match not reported");
  a_preret_alone: assert property (@(posedge sys_clk) disable iff (!rstSync_q)
    traceReq && traceRecord[`TREC_PRERET] |-> traceRecord == (`TREC_W'(1) << `TREC_PRERET))
    else $error("prereturn shared a record");
  a_preret_defer: assert property (@(posedge sys_clk) disable iff (!rstSync_q)
    state_q == trace_bkpt_pkg::ST_IDLE && evts[`TREC_PRERET] && others != '0
    |=> traceReq && !traceRecord[`TREC_PRERET] && prereturnPending)
    else $error("prereturn not deferred");
  a_trace_entry_off: assert property (@(posedge sys_clk) disable iff (!rstSync_q)
    callValid && callKind == trace_bkpt_pkg::FLT_TRACE |=> !traceEnable &&
    pfpReturnType == `RET_FAULT)
    else $error("trace handler entry wrong");
  a_user_sys_call: assert property (@(posedge sys_clk) disable iff (!rstSync_q)
    callValid && callKind == trace_bkpt_pkg::CALL_SYS && !execSuper |=>
    traceEnable == $past(sspTe_q) && pfpReturnType == {`RET_SYS_HIGH, $past(traceEnable)})
    else $error("user system call flag wrong");
  a_intr_entry: assert property (@(posedge sys_clk) disable iff (!rstSync_q)
    callValid && callKind == trace_bkpt_pkg::CALL_INTR |=> !traceEnable &&
    pfpReturnType == `RET_INTR && intSavedTrace == $past(traceEnable) && !traceReq)
    else $error("interrupt entry wrong");
  a_local_keep: assert property (@(posedge sys_clk) disable iff (!rstSync_q)
    callValid && callKind == trace_bkpt_pkg::CALL_LOCAL && !retValid |=>
    $stable(traceEnable) && pfpReturnType == `RET_LOCAL)
    else $error("local call altered trace flag");
  a_fault_ip_undef: assert property (@(posedge sys_clk) disable iff (!rstSync_q)
    isFaultCall && evts[`TREC_CALL] |=> !faultIpDefined)
    else $error("fault ip defined on traced fault call");
  a_word_store: assert property (@(posedge sys_clk) disable iff (!rstSync_q)
    storeHit && !sysctlValid |=> ibp_q[$past(storeIdx)] == $past(storeData))
    else $error("word store not applied");
endmodule : trace_breakpoint_fault_unit

// *** verification/trace_dispatch_model.sv ***
/*
  Fault dispatch model: answers each trace request with a trace
  handler entry and, later, a handler return.
  Assumes one request at a time; slowMode stretches waits.
*/
`timescale 1ns/10ps
module trace_dispatch_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Request side
  input wire logic traceReq,
  input wire logic slowMode,
  // Dispatch actions
  output logic hCall,
  output logic hRet,
  output logic busy
);
  logic [1:0] ph_q;
  logic [3:0] cnt_q;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ph_q <= 2'h0;
      cnt_q <= 4'h0;
      hCall <= 1'b0;
      hRet <= 1'b0;
    end else begin
      hCall <= 1'b0;
      hRet <= 1'b0;
      case (ph_q)
        2'h0: if (traceReq) begin
          ph_q <= 2'h1;
          cnt_q <= slowMode ? 4'h6 : 4'h0;
        end
        2'h1: if (cnt_q == 4'h0) begin
          hCall <= 1'b1;
          ph_q <= 2'h2;
          cnt_q <= slowMode ? 4'h9 : 4'h2;
        end else cnt_q <= cnt_q - 4'h1;
        default: if (cnt_q == 4'h0) begin
          // Return restores the flag set before the trace
          hRet <= 1'b1;
          ph_q <= 2'h0;
        end else cnt_q <= cnt_q - 4'h1;
      endcase
    end
  end

  assign busy = (ph_q != 2'h0) || hRet;
endmodule : trace_dispatch_model

// *** verification/trace_breakpoint_fault_unit_tb_top.sv ***
/*
  Self-checking bench of the trace and breakpoint fault unit.
  Assumes the dispatch model answers each request.
*/
`timescale 1ns/10ps
`include "trace_bkpt_regs.svh"
module trace_breakpoint_fault_unit_tb_top;
  logic sys_clk, arst_n, sysctlValid, sysctlWrite, sysctlRvalid, storeValid, retireValid;
  logic [0:0] sysctlIndex;
  logic [31:0] sysctlWdata, sysctlRdata, storeAddr, storeData, retireIp, accAddr;
  logic groupEvt, supervisorEvt, markEvt, fmarkEvt, prereturnEvt, accValid, accWrite;
  logic [3:0] storeByteEn;
  logic breakpointTraceMode, callTraceMode, callValid, tCall, execSuper, tSuper;
  logic [2:0] accSizeLog, retType, tRetType, pfpReturnType;
  logic [1:0][31:0] dabAddr;
  logic [1:0] dabEn;
  logic [1:0][1:0] dabMode;
  logic sptTraceBit, initLoad, initSspTraceBit, retValid, tRet, retTraceRestore, tRestore;
  trace_bkpt_pkg::call_kind_type callKind, tKind;
  logic traceEnable, intSavedTrace, traceReq, faultIpDefined, prereturnPending;
  logic [7:0] traceRecord;
  logic hCall, hRet, busy, slowMode;
  logic [7:0] recQ[$];
  int err_total = 0;
  int comparisons = 0;
  int cyc = 0;

  // Dispatch model owns handler entry and return when busy
  assign callValid = tCall | hCall;
  assign callKind = hCall ? trace_bkpt_pkg::FLT_TRACE : tKind;
  assign retValid = tRet | hRet;
  assign retType = hRet ? `RET_FAULT : tRetType;
  assign retTraceRestore = hRet ? 1'b1 : tRestore;
  assign execSuper = hRet | tSuper;

  trace_breakpoint_fault_unit #(.NUM_IBP(2), .NUM_DAB(2), .IDX_W(1))
    u_trace_breakpoint_fault_unit (.sys_clk, .arst_n, .sysctlValid, .sysctlWrite,
    .sysctlIndex, .sysctlWdata, .sysctlRvalid, .sysctlRdata, .storeValid, .storeAddr,
    .storeByteEn, .storeData, .retireValid, .retireIp, .groupEvt, .supervisorEvt, .markEvt,
    .fmarkEvt, .prereturnEvt, .breakpointTraceMode, .callTraceMode, .accValid, .accWrite,
    .accAddr, .accSizeLog, .dabAddr, .dabEn, .dabMode, .callValid, .callKind, .execSuper,
    .sptTraceBit, .initLoad, .initSspTraceBit, .retValid, .retType, .retTraceRestore,
    .traceHandlerDone(hRet), .traceEnable, .pfpReturnType, .intSavedTrace, .traceReq,
    .traceRecord, .faultIpDefined, .prereturnPending);

  trace_dispatch_model u_trace_dispatch_model (.sys_clk, .arst_n, .traceReq, .slowMode,
    .hCall, .hRet, .busy);

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (traceReq === 1'b1) recQ.push_back(traceRecord);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      $display("MISMATCH t=%0t run did not finish", $time);
      test_done();
    end
  end

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask : tick

  // Quiet: four cycles, no request, dispatcher idle
  task automatic waitIdle();
    int q;
    q = 0;
    for (int i = 0; i < 300 && q < 4; i++) begin
      @(posedge sys_clk);
      q = (busy === 1'b0 && traceReq === 1'b0) ? q + 1 : 0;
    end
    #1;
  endtask : waitIdle

  task automatic chkRecs(input int n, input logic [7:0] a, input logic [7:0] b);
    waitIdle();
    chk(32'(recQ.size()), 32'(n), "record count");
    if (n > 0 && recQ.size() > 0) chk(32'(recQ[0]), 32'(a), "first record");
    if (n > 1 && recQ.size() > 1) chk(32'(recQ[1]), 32'(b), "second record");
    recQ.delete();
  endtask : chkRecs

  task automatic sysWr(input logic i, input logic [31:0] d);
    sysctlValid = 1; sysctlWrite = 1; sysctlIndex = i; sysctlWdata = d;
    tick();
    sysctlValid = 0;
  endtask : sysWr

  task automatic sysRd(input logic i, input logic [31:0] e);
    sysctlValid = 1; sysctlWrite = 0; sysctlIndex = i;
    tick();
    sysctlValid = 0;
    chk(32'(sysctlRvalid), 32'h1, "read valid");
    chk(sysctlRdata, e, "read data");
    tick();
    chk(32'(sysctlRvalid), 32'h0, "read valid drop");
  endtask : sysRd

  task automatic st(input logic [31:0] a, input logic [3:0] be, input logic [31:0] d);
    storeValid = 1; storeAddr = a; storeByteEn = be; storeData = d;
    tick();
    storeValid = 0;
  endtask : st

  task automatic retire(input logic [31:0] ip, input logic [4:0] ev);
    retireValid = 1; retireIp = ip;
    {prereturnEvt, fmarkEvt, markEvt, supervisorEvt, groupEvt} = ev;
    tick();
    retireValid = 0;
    {prereturnEvt, fmarkEvt, markEvt, supervisorEvt, groupEvt} = 5'h0;
  endtask : retire

  task automatic call(input trace_bkpt_pkg::call_kind_type k, input logic s);
    tKind = k; tSuper = s; tCall = 1;
    tick();
    tCall = 0;
  endtask : call

  task automatic rtn(input logic [2:0] t, input logic r);
    tRet = 1; tRetType = t; tSuper = 1; tRestore = r;
    tick();
    tRet = 0;
  endtask : rtn

  task automatic initSsp(input logic b);
    initSspTraceBit = b; initLoad = 1;
    tick();
    initLoad = 0;
  endtask : initSsp

  // {flag after call, return type}
  function automatic logic [3:0] callExp(input trace_bkpt_pkg::call_kind_type k,
      input logic te, input logic s, input logic ssp, input logic system_procedure_table);
    case (k)
      trace_bkpt_pkg::CALL_LOCAL: return {te, `RET_LOCAL};
      trace_bkpt_pkg::CALL_SYS: return s ? {te, `RET_LOCAL} : {ssp, `RET_SYS_HIGH, te};
      trace_bkpt_pkg::FLT_LOCAL, trace_bkpt_pkg::FLT_SYSLOCAL: return {te, `RET_FAULT};
      trace_bkpt_pkg::FLT_SUPER: return {system_procedure_table, `RET_FAULT};
      trace_bkpt_pkg::CALL_INTR: return {1'b0, `RET_INTR};
      default: return {1'b0, `RET_FAULT};
    endcase
  endfunction : callExp

  function automatic logic [7:0] recExp(input logic [4:0] ev, input logic bpm);
    return {1'b0, ev[1], 2'b00, ev[3], ev[2] & bpm, 1'b0, ev[0]};
  endfunction : recExp

  initial begin
    trace_bkpt_pkg::call_kind_type k;
    logic ssp, system_procedure_table, s, flt, teM, teOld, w, h;
    logic [3:0] e;
    logic [4:0] ev;
    logic [31:0] d, a;
    logic [2:0] l;
    {sysctlValid, sysctlWrite, sysctlIndex, sysctlWdata, storeValid, storeAddr} = '0;
    {storeByteEn, storeData, retireValid, retireIp, groupEvt, supervisorEvt, markEvt} = '0;
    {fmarkEvt, prereturnEvt, breakpointTraceMode, callTraceMode, accValid, accWrite} = '0;
    {accAddr, accSizeLog, dabAddr, dabEn, dabMode, tCall, tSuper, sptTraceBit} = '0;
    {initLoad, initSspTraceBit, tRet, tRetType, tRestore, slowMode} = '0;
    tKind = trace_bkpt_pkg::CALL_LOCAL;
    arst_n = 0;
    void'($urandom(37));
    repeat (20) @(posedge sys_clk);
    #1 arst_n = 1;
    repeat (3) tick();
    chk(32'(traceEnable), 32'h0, "reset flag");
    chk(32'(faultIpDefined), 32'h1, "reset fault ip");
    chk(32'(pfpReturnType), 32'h0, "reset ret type");
    for (int i = 0; i < 2; i++) begin
      sysRd(i[0], `IBP_RESET);
      d = $urandom;
      sysWr(i[0], d);
      sysRd(i[0], d);
      d = $urandom;
      st(`IBP_BASE_ADDR + 32'(4 * i), `WORD_STROBE, d);
      sysRd(i[0], d);
      st(`IBP_BASE_ADDR + 32'(4 * i), 4'h3, ~d);
      st(`IBP_BASE_ADDR + 32'(4 * i + 1), `WORD_STROBE, ~d);
      sysRd(i[0], d);
    end
    $display("Test registers done");
    teM = 0;
    for (int i = 0; i < 32; i++) begin
      k = trace_bkpt_pkg::call_kind_type'(i % 8);
      ssp = 1'($urandom); system_procedure_table = 1'($urandom); s = 1'($urandom);
      callTraceMode = 1'($urandom); sptTraceBit = system_procedure_table; slowMode = 1'($urandom);
      initSsp(ssp);
      e = callExp(k, teM, s, ssp, system_procedure_table);
      teOld = teM;
      call(k, s);
      chk(32'(traceEnable), 32'(e[3]), "call flag");
      chk(32'(pfpReturnType), 32'(e[2:0]), "call type");
      flt = k inside {trace_bkpt_pkg::FLT_LOCAL, trace_bkpt_pkg::FLT_SYSLOCAL,
        trace_bkpt_pkg::FLT_SUPER};
      if (flt) chk(32'(faultIpDefined), 32'(!(e[3] && callTraceMode)), "fault ip");
      if (k == trace_bkpt_pkg::CALL_INTR) chk(32'(intSavedTrace), 32'(teOld), "saved");
      if (flt || k >= trace_bkpt_pkg::FLT_TRACE) begin
        chkRecs(flt && e[3] && callTraceMode, 8'h02, 8'h0);
      end else begin
        waitIdle();
        recQ.delete();
      end
      teM = e[3];
      if (k == trace_bkpt_pkg::CALL_INTR || k == trace_bkpt_pkg::CALL_LOCAL) begin
        if (k == trace_bkpt_pkg::CALL_INTR) teM = teOld;
        rtn(k == trace_bkpt_pkg::CALL_INTR ? `RET_INTR : `RET_LOCAL,
          teM ^ (k == trace_bkpt_pkg::CALL_LOCAL));
        chk(32'(traceEnable), 32'(teM), "return flag");
      end
    end
    $display("Test calls done");
    callTraceMode = 0;
    initSsp(1);
    call(trace_bkpt_pkg::CALL_SYS, 0);
    waitIdle();
    recQ.delete();
    st(`IBP_BASE_ADDR, `WORD_STROBE, 32'h0000_8003);
    retire(32'h0000_8001, 5'h00);
    chkRecs(1, 8'h10, 8'h0);
    retire(32'h0000_8000, 5'h09);
    chkRecs(1, 8'h19, 8'h0);
    for (int m = 0; m < 3; m++) begin
      sysWr(1, 32'h0000_9000 | 32'(m));
      retire(32'h0000_9000, 5'h00);
      chkRecs(0, 8'h0, 8'h0);
    end
    call(trace_bkpt_pkg::CALL_INTR, 1);
    retire(32'h0000_8000, 5'h08);
    chkRecs(0, 8'h0, 8'h0);
    rtn(`RET_INTR, 1);
    chk(32'(traceEnable), 32'h1, "restore");
    $display("Test breakpoints done");
    dabEn = 2'b01; dabMode[0] = `DAB_MODE_READ; dabAddr[0] = 32'h0000_100f;
    for (int i = 0; i < 12; i++) begin
      a = (i < 4) ? 32'h0000_1000 + 32'(i * 4) : 32'h0000_0ff0 + ($urandom & 32'h1f);
      l = (i < 4) ? 3'(4 - i) : 3'($urandom % 5);
      w = (i < 4) ? (i == 2) : 1'($urandom);
      h = !w && a <= 32'h0000_100f && 32'h0000_100f < a + (32'h1 << l);
      accValid = 1; accWrite = w; accAddr = a; accSizeLog = l;
      tick();
      accValid = 0;
      chkRecs(h, 8'h20, 8'h0);
    end
    dabEn = 2'b00;
    $display("Test data match done");
    for (int i = 0; i < 40; i++) begin
      ev = 5'($urandom) & 5'h0f;
      breakpointTraceMode = 1'($urandom); slowMode = 1'($urandom);
      retire({4'h1, 28'($urandom)}, ev);
      chkRecs(recExp(ev, breakpointTraceMode) != 8'h0,
        recExp(ev, breakpointTraceMode), 8'h0);
    end
    $display("Test events done");
    slowMode = 1; breakpointTraceMode = 1;
    retire(32'h1000_0000, 5'h14);
    chk(32'(prereturnPending), 32'h1, "pending");
    for (int i = 0; i < 20 && hCall !== 1'b1; i++) tick();
    tick();
    chk(32'(traceEnable), 32'h0, "flag in handler");
    chkRecs(2, 8'h04, 8'h80);
    chk(32'(prereturnPending), 32'h0, "pending clear");
    $display("Test prereturn done");
    test_done();
  end
endmodule : trace_breakpoint_fault_unit_tb_top
